// >>> mcc_pkg.sv
package mcc_pkg;
    // ----------------------------------------
    // register map (word addresses, byte addr = 4 * index)
    // ----------------------------------------
    localparam logic [3:0] REG_TIMER = 4'h0;
    localparam logic [3:0] REG_PREV_CAP = 4'h1;
    localparam logic [3:0] REG_CURR_CAP = 4'h2;
    localparam logic [3:0] REG_NEXT_CMP = 4'h3;
    localparam logic [3:0] REG_WEIGHT = 4'h4;
    localparam logic [3:0] REG_PRESCALE = 4'h5;
    localparam logic [3:0] REG_INT_MASK = 4'h6;
    localparam logic [3:0] REG_INT_STAT = 4'h7;
    localparam logic [3:0] REG_CTRL_A = 4'h8;
    localparam logic [3:0] REG_CTRL_B = 4'h9;
    localparam logic [3:0] REG_PHASE = 4'ha;
    localparam int ADDR_W = 6;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int MASK_HYST = 7;
    localparam int MASK_CLOOP = 6;
    localparam int MASK_DEMAG = 1;
    localparam int CTRL_OE = 7;
    localparam int CTRL_CLR = 6;
    localparam int CTRL_SENSOR = 5;
    localparam int CTRL_DIRECT = 4;
    localparam int CTRL_CURMODE = 3;
    localparam int CTRL_AUTOSW = 2;
    localparam int CTRL_FILTER = 1;
    localparam int CTRL_CAPSEL = 0;
    localparam int CTRLB_HWDEM = 4;
    localparam int CTRLB_SWDEM = 3;
    localparam int CTRLB_ALTPWM = 2;
    // status bit positions: incr, decr, ovf, estop, zc, demag, comm
    localparam int ST_INC = 6;
    localparam int ST_DEC = 5;
    localparam int ST_OVF = 4;
    localparam int ST_EST = 3;
    localparam int ST_ZC = 2;
    localparam int ST_DEM = 1;
    localparam int ST_COM = 0;
    localparam int WEIGHT_SHIFT = 5; // divide by 32

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic incr;
        logic decr;
        logic overflow;
        logic estop;
        logic zero_cross;
        logic demag_end;
        logic commutation;
    } mcc_events_t;

    typedef struct packed {
        logic [5:0] level;
        logic [5:0] oe_n;
    } mcc_phase_out_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } mcc_bus_state_t;
endpackage

// >>> mcc_regs.sv
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - autoswitched: zero-crossing loads next compare with capture times weight over 32
// - capture operand select: 0 previous capture, 1 current capture
// - upper prescale nibble holds the current-mode sampling ratio
// - lower prescale nibble is step ratio, counts up on increment, down on decrement
// - mask bit 7 reads the hysteresis comparator, read only
// - mask bit 6 reads the current-loop comparator, read only
// - mask bits 5..0 enable ratio, overflow, estop, crossing, demag, commutation
// - demag interrupt needs its mask bit and hardware or software demag enable
// - status bit 7 always reads zero
// - status bits 6..0 are pending flags, 1 means pending
// - switched mode increment flag: step up at commutation, timers shift right
// - switched mode decrement flag: step down at commutation, timers shift left
// - output enable clear: outputs high impedance and unit clocks stopped
// - writing 1 to the clear bit resets all unit registers
// - sensor select: 0 sensorless both phases, 1 sensor ignoring alternate pwm
// - without direct access, preloaded registers transfer at commutation
// - direct access: phase writes drive outputs statically, preloads at once, timer stops
// - stopped clock keeps timer value, timer stays writable
// - current-mode select: 0 voltage, 1 current mode
// - auto-switch: 0 next compare writable, 1 next compare read only
// - filter bit enables the current feedback filter
// - interrupts need their enable and a clear global processor mask
module mcc_regs (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [mcc_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic hyst_comp_i,
    input wire logic cloop_comp_i,
    input wire logic global_mask_i,
    input wire logic zero_cross_i,
    input wire logic [7:0] zero_cross_capture_i,
    input wire logic commutation_i,
    input wire logic demag_end_i,
    input wire logic estop_i,
    input wire logic ratio_inc_i,
    input wire logic ratio_dec_i,
    output mcc_pkg::mcc_phase_out_t phase_o,
    output logic [5:0] irq_req_o,
    output logic unit_clk_en_o,
    output logic timer_shift_right_o,
    output logic timer_shift_left_o,
    output logic sensor_mode_o,
    output logic alt_pwm_o,
    output logic current_mode_o,
    output logic filter_en_o,
    output logic [3:0] sampling_ratio_o
);
    import mcc_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        mcc_bus_state_t bus;
        logic [31:0] rdata;
        logic [7:0] timer;
        logic [7:0] prev_cap;
        logic [7:0] curr_cap;
        logic [7:0] next_cmp;
        logic [7:0] weight;
        logic [7:0] prescale;
        logic [5:0] mask;
        logic [6:0] status;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] ctrl_b_pre;
        logic [7:0] phase;
        logic [7:0] phase_pre;
        mcc_phase_out_t pins;
        logic [5:0] irq;
        logic clk_en;
        logic shr;
        logic shl;
        logic sensor;
        logic altpwm;
        logic curmode;
        logic filt;
        logic [3:0] sratio;
    } mcc_state_t;

    mcc_state_t st_r;
    mcc_state_t st_nxt;

    // weight product scaled by 1/32
    function automatic logic [10:0] scale_product(input logic [7:0] a, input logic [7:0] b);
        logic [15:0] p;
        p = {8'h00, a} * {8'h00, b};
        return p[15:WEIGHT_SHIFT];
    endfunction

    // byte lane 0 merge
    function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
        return be[0] ? wd[7:0] : old;
    endfunction

    logic wr_acc;
    logic rd_acc;
    logic [3:0] widx;
    logic [10:0] prod;
    logic [7:0] wbyte;
    logic [6:0] hw_set;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        widx = avs_address_i[5:2];
        wr_acc = (st_r.bus == BUS_ACK) && avs_write_i; // write lands at the ack edge only
        rd_acc = (st_r.bus == BUS_IDLE) && avs_read_i;
        wbyte = avs_writedata_i[7:0];
        prod = scale_product(st_r.ctrl_a[CTRL_CAPSEL] ? st_r.curr_cap : st_r.prev_cap,
                             st_r.weight);
        // hardware set events of this cycle, in status bit order
        hw_set = {ratio_inc_i, ratio_dec_i,
                  zero_cross_i && st_r.ctrl_a[CTRL_AUTOSW] && (prod > 11'h0ff),
                  estop_i, zero_cross_i, demag_end_i, commutation_i};

        // one wait cycle, then ack
        st_nxt.bus = ((st_r.bus == BUS_IDLE) && (avs_write_i || avs_read_i)) ? BUS_ACK
            : BUS_IDLE;

        // capture chain on zero crossing
        if (zero_cross_i) begin
            st_nxt.prev_cap = st_r.curr_cap;
            st_nxt.curr_cap = zero_cross_capture_i;
            st_nxt.status[ST_ZC] = 1'b1;
            if (st_r.ctrl_a[CTRL_AUTOSW]) begin
                if (prod > 11'h0ff) begin
                    st_nxt.status[ST_OVF] = 1'b1;
                    st_nxt.next_cmp = 8'hff;
                end else begin
                    st_nxt.next_cmp = prod[7:0];
                end
            end
        end

        // timer counts only with clock running, else holds
        if (st_r.clk_en) begin
            st_nxt.timer = st_r.timer + 8'h01;
        end

        // step ratio update
        st_nxt.shr = 1'b0;
        st_nxt.shl = 1'b0;
        if (st_r.ctrl_a[CTRL_AUTOSW]) begin
            if (ratio_inc_i) begin
                st_nxt.prescale[3:0] = st_r.prescale[3:0] + 4'h1;
                st_nxt.status[ST_INC] = 1'b1;
            end else if (ratio_dec_i) begin
                st_nxt.prescale[3:0] = st_r.prescale[3:0] - 4'h1;
                st_nxt.status[ST_DEC] = 1'b1;
            end
        end else begin
            if (ratio_inc_i) begin
                st_nxt.status[ST_INC] = 1'b1;
            end
            if (ratio_dec_i) begin
                st_nxt.status[ST_DEC] = 1'b1;
            end
        end

        if (commutation_i) begin
            st_nxt.status[ST_COM] = 1'b1;
            if (!st_r.ctrl_a[CTRL_AUTOSW] && st_r.status[ST_INC]) begin
                st_nxt.prescale[3:0] = st_r.prescale[3:0] + 4'h1;
                st_nxt.timer = {1'b0, st_r.timer[7:1]};
                st_nxt.shr = 1'b1;
                st_nxt.status[ST_INC] = ratio_inc_i;
            end else if (!st_r.ctrl_a[CTRL_AUTOSW] && st_r.status[ST_DEC]) begin
                st_nxt.prescale[3:0] = st_r.prescale[3:0] - 4'h1;
                st_nxt.timer = {st_r.timer[6:0], 1'b0};
                st_nxt.shl = 1'b1;
                st_nxt.status[ST_DEC] = ratio_dec_i;
            end
            if (!st_r.ctrl_a[CTRL_DIRECT]) begin
                st_nxt.ctrl_b = st_r.ctrl_b_pre;
                st_nxt.phase = st_r.phase_pre;
            end
        end
        if (estop_i) begin
            st_nxt.status[ST_EST] = 1'b1;
        end
        if (demag_end_i) begin
            st_nxt.status[ST_DEM] = 1'b1;
        end

        // register writes; hardware sets win over software clears
        if (wr_acc && avs_byteenable_i[0]) begin
            unique case (widx)
                REG_TIMER: st_nxt.timer = wbyte;
                REG_PREV_CAP: st_nxt.prev_cap = wbyte;
                REG_CURR_CAP: st_nxt.curr_cap = wbyte;
                REG_NEXT_CMP: begin
                    if (!st_r.ctrl_a[CTRL_AUTOSW]) begin
                        st_nxt.next_cmp = wbyte;
                    end
                end
                REG_WEIGHT: st_nxt.weight = wbyte;
                REG_PRESCALE: st_nxt.prescale = wbyte;
                REG_INT_MASK: st_nxt.mask = wbyte[5:0];
                REG_INT_STAT: st_nxt.status = (wbyte[6:0] & st_nxt.status) | hw_set;
                REG_CTRL_A: st_nxt.ctrl_a = {wbyte[7], 1'b0, wbyte[5:0]};
                REG_CTRL_B: begin
                    st_nxt.ctrl_b_pre = wbyte;
                    if (st_r.ctrl_a[CTRL_DIRECT]) begin
                        st_nxt.ctrl_b = wbyte;
                    end
                end
                REG_PHASE: begin
                    st_nxt.phase_pre = wbyte;
                    if (st_r.ctrl_a[CTRL_DIRECT]) begin
                        st_nxt.phase = wbyte;
                    end
                end
                default: ;
            endcase
        end

        // read mux
        st_nxt.rdata = st_r.rdata;
        if (rd_acc) begin
            unique case (widx)
                REG_TIMER: st_nxt.rdata = {24'h0, st_r.timer};
                REG_PREV_CAP: st_nxt.rdata = {24'h0, st_r.prev_cap};
                REG_CURR_CAP: st_nxt.rdata = {24'h0, st_r.curr_cap};
                REG_NEXT_CMP: st_nxt.rdata = {24'h0, st_r.next_cmp};
                REG_WEIGHT: st_nxt.rdata = {24'h0, st_r.weight};
                REG_PRESCALE: st_nxt.rdata = {24'h0, st_r.prescale};
                REG_INT_MASK: st_nxt.rdata = {24'h0, hyst_comp_i, cloop_comp_i,
                                              st_r.mask};
                REG_INT_STAT: st_nxt.rdata = {24'h0, 1'b0, st_r.status};
                REG_CTRL_A: st_nxt.rdata = {24'h0, st_r.ctrl_a};
                REG_CTRL_B: st_nxt.rdata = {24'h0, st_r.ctrl_b_pre};
                REG_PHASE: st_nxt.rdata = {24'h0, st_r.phase_pre};
                default: st_nxt.rdata = UNMAPPED_DATA;
            endcase
        end

        // clocks run only with outputs on and no direct access
        st_nxt.clk_en = st_nxt.ctrl_a[CTRL_OE] && !st_nxt.ctrl_a[CTRL_DIRECT];

        // output pins
        st_nxt.pins.level = st_nxt.phase[5:0];
        st_nxt.pins.oe_n = st_nxt.ctrl_a[CTRL_OE] ? 6'h00 : 6'h3f;

        // interrupt requests per source
        st_nxt.irq[5] = (st_nxt.status[ST_INC] | st_nxt.status[ST_DEC]) & st_nxt.mask[5];
        st_nxt.irq[4:2] = st_nxt.status[ST_OVF:ST_ZC] & st_nxt.mask[4:2];
        st_nxt.irq[1] = st_nxt.status[ST_DEM] & st_nxt.mask[MASK_DEMAG]
            & (st_nxt.ctrl_b[CTRLB_HWDEM] | st_nxt.ctrl_b[CTRLB_SWDEM]);
        st_nxt.irq[0] = st_nxt.status[ST_COM] & st_nxt.mask[0];
        if (global_mask_i) begin
            st_nxt.irq = 6'h00;
        end

        st_nxt.sensor = st_nxt.ctrl_a[CTRL_SENSOR];
        st_nxt.altpwm = st_nxt.ctrl_b[CTRLB_ALTPWM] & ~st_nxt.ctrl_a[CTRL_SENSOR];
        st_nxt.curmode = st_nxt.ctrl_a[CTRL_CURMODE];
        st_nxt.filt = st_nxt.ctrl_a[CTRL_FILTER];
        st_nxt.sratio = st_nxt.prescale[7:4];

        // soft clear of every unit register
        if (wr_acc && avs_byteenable_i[0] && widx == REG_CTRL_A && wbyte[CTRL_CLR]) begin
            st_nxt = '0;
            st_nxt.bus = BUS_IDLE;
            st_nxt.pins.oe_n = 6'h3f;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
            st_r.bus <= BUS_IDLE;
            st_r.pins.oe_n <= 6'h3f;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata_o = st_r.rdata;
    assign avs_waitrequest_o = (st_r.bus == BUS_IDLE);
    assign phase_o = st_r.pins;
    assign irq_req_o = st_r.irq;
    assign unit_clk_en_o = st_r.clk_en;
    assign timer_shift_right_o = st_r.shr;
    assign timer_shift_left_o = st_r.shl;
    assign sensor_mode_o = st_r.sensor;
    assign alt_pwm_o = st_r.altpwm;
    assign current_mode_o = st_r.curmode;
    assign filter_en_o = st_r.filt;
    assign sampling_ratio_o = st_r.sratio;
endmodule

// >>> mcc_regs_asserts.sv
`timescale 1ns/10ps
module mcc_regs_asserts (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [mcc_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic hyst_comp_i,
    input wire logic cloop_comp_i,
    input wire logic global_mask_i,
    input wire logic commutation_i,
    input wire mcc_pkg::mcc_phase_out_t phase_o,
    input wire logic [5:0] irq_req_o,
    input wire logic unit_clk_en_o,
    input wire logic timer_shift_right_o,
    input wire logic timer_shift_left_o
);
    import mcc_pkg::*;
    logic [3:0] idx;
    logic ack_rd;
    logic ack_wa;
    // acknowledged reads and control writes
    assign idx = avs_address_i[5:2];
    assign ack_rd = avs_read_i && !avs_waitrequest_o;
    assign ack_wa = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && idx == REG_CTRL_A;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    a_ack_next: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not acknowledged");
    a_cmp_read: assert property (ack_rd && idx == REG_INT_MASK |-> avs_readdata_o[7:6]
        == {$past(hyst_comp_i), $past(cloop_comp_i)}) else $error("comparator bits");
    a_status_msb: assert property (ack_rd && idx == REG_INT_STAT
        |-> !avs_readdata_o[7]) else $error("status bit 7 set");
    a_global_block: assert property (global_mask_i
        |=> irq_req_o == 6'h00) else $error("irq despite global mask");
    a_shift_once: assert property (timer_shift_right_o
        |-> !timer_shift_left_o ##1 !timer_shift_right_o) else $error("shift pulse");
    a_shift_cause: assert property (timer_shift_right_o || timer_shift_left_o
        |-> $past(commutation_i)) else $error("shift without commutation");
    a_oe_hiz: assert property (ack_wa && !avs_writedata_i[7]
        |=> phase_o.oe_n == 6'h3f) else $error("outputs not released");
    a_clk_gate: assert property (ack_wa |=> unit_clk_en_o == ($past(avs_writedata_i[7:6])
        == 2'b10 && !$past(avs_writedata_i[4]))) else $error("unit clock gate");
endmodule
bind mcc_regs mcc_regs_asserts u_mcc_regs_asserts (.clk_sys_i, .sys_rst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .hyst_comp_i, .cloop_comp_i, .global_mask_i, .commutation_i,
    .phase_o, .irq_req_o, .unit_clk_en_o, .timer_shift_right_o, .timer_shift_left_o);

// >>> mcc_stage_model.sv
`timescale 1ns/10ps
module mcc_stage_model (
    input wire logic clk_sys_i,
    input wire mcc_pkg::mcc_events_t cmd_i,
    input wire logic [7:0] cap_i,
    input wire logic [1:0] cmp_i,
    input wire mcc_pkg::mcc_phase_out_t phase_i,
    output mcc_pkg::mcc_events_t ev_o,
    output logic [7:0] cap_o,
    output logic hyst_o,
    output logic cloop_o,
    output logic [5:0] pin_o
);
    import mcc_pkg::*;
    logic [5:0] last_r;
    // comparator levels and one-cycle event pulses
    always_ff @(posedge clk_sys_i) begin
        ev_o <= cmd_i;
        cap_o <= cap_i;
        {hyst_o, cloop_o} <= cmp_i;
        last_r <= pin_o;
    end
    // a released pin shows the inverse of its last level
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            pin_o[i] = phase_i.oe_n[i] ? ~last_r[i] : phase_i.level[i];
        end
    end
endmodule

// >>> testbench.sv
`timescale 1ns/10ps
module testbench;
    import mcc_pkg::*;
    localparam mcc_events_t INC = 7'h40;
    localparam mcc_events_t DEC = 7'h20;
    localparam mcc_events_t ZC = 7'h04;
    localparam mcc_events_t DEM = 7'h02;
    localparam mcc_events_t COM = 7'h01;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic gmask = 1'b0;
    logic [31:0] wdata = '0;
    logic [31:0] rdo;
    logic [31:0] rdata;
    logic wreq, hyst, cloop, ck_en, sens, alt, cmode, filt;
    logic [1:0] cmp = 2'b00;
    logic [7:0] cap = '0;
    logic [7:0] capq;
    logic [5:0] irq, pins;
    logic [3:0] samp;
    mcc_events_t cmd = '0;
    mcc_events_t ev;
    mcc_phase_out_t ph;
    int n_errors = 0;
    int comparisons = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    mcc_regs u_mcc_regs (.clk_sys_i, .sys_rst_i, .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'h1),
        .avs_readdata_o(rdo), .avs_waitrequest_o(wreq), .hyst_comp_i(hyst),
        .cloop_comp_i(cloop), .global_mask_i(gmask), .zero_cross_i(ev.zero_cross),
        .zero_cross_capture_i(capq), .commutation_i(ev.commutation),
        .demag_end_i(ev.demag_end), .estop_i(ev.estop), .ratio_inc_i(ev.incr),
        .ratio_dec_i(ev.decr), .phase_o(ph), .irq_req_o(irq), .unit_clk_en_o(ck_en),
        .timer_shift_right_o(), .timer_shift_left_o(), .sensor_mode_o(sens),
        .alt_pwm_o(alt), .current_mode_o(cmode), .filter_en_o(filt),
        .sampling_ratio_o(samp));
    mcc_stage_model u_mcc_stage_model (.clk_sys_i, .cmd_i(cmd), .cap_i(cap), .cmp_i(cmp),
        .phase_i(ph), .ev_o(ev), .cap_o(capq), .hyst_o(hyst), .cloop_o(cloop), .pin_o(pins));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] idx, input logic [7:0] d);
        addr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        rd <= !w;
        wr <= w;
        do @(posedge clk_sys_i); while (wreq !== 1'b0);
        rdata = rdo;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic rg(input logic [3:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rdata, {24'h0, exp});
    endtask
    task automatic ep(input mcc_events_t e, input logic [7:0] c);
        cmd <= e;
        cap <= c;
        @(posedge clk_sys_i);
        cmd <= '0;
        repeat (3) @(posedge clk_sys_i);
    endtask
    function automatic logic [7:0] mul(input logic [7:0] z, input logic [7:0] w);
        logic [15:0] p;
        p = (16'(z) * 16'(w)) >> 5;
        return (p > 16'h00ff) ? 8'hff : p[7:0];
    endfunction
    task automatic conclude();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk_sys_i);
        n_errors++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_sys_i);
        for (int i = 4; i < 9; i++) rg(i[3:0], RESET_BYTE);
        rg(4'hf, 8'h00);
        bus(1'b1, REG_WEIGHT, 8'h40);
        bus(1'b1, REG_CTRL_A, 8'h85);
        ep(ZC, 8'h50);
        ep(ZC, 8'h60);
        rg(REG_NEXT_CMP, mul(8'h50, 8'h40));
        bus(1'b1, REG_WEIGHT, 8'h20);
        bus(1'b1, REG_CTRL_A, 8'h84);
        ep(ZC, 8'h70);
        rg(REG_NEXT_CMP, mul(8'h50, 8'h20));
        bus(1'b1, REG_NEXT_CMP, 8'h12);
        rg(REG_NEXT_CMP, mul(8'h50, 8'h20));
        bus(1'b1, REG_WEIGHT, 8'hff);
        ep(ZC, 8'hff);
        rg(REG_NEXT_CMP, mul(8'h60, 8'hff));
        rg(REG_INT_STAT, 8'h14);
        bus(1'b1, REG_INT_STAT, 8'h00);
        $display("multiplier test done");
        cmp <= 2'b10;
        bus(1'b1, REG_INT_MASK, 8'h06);
        rg(REG_INT_MASK, 8'h86);
        ep(ZC | DEM, 8'h10);
        chk(irq, 6'h04);
        bus(1'b1, REG_CTRL_B, 8'h08);
        ep(COM, 8'h00);
        chk(irq, 6'h06);
        gmask <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        chk(irq, 6'h00);
        gmask <= 1'b0;
        cmp <= 2'b01;
        bus(1'b1, REG_INT_MASK, 8'h3f);
        rg(REG_INT_MASK, 8'h7f);
        $display("interrupt test done");
        bus(1'b1, REG_PRESCALE, 8'h95);
        chk(samp, 4'h9);
        ep(INC, 8'h00);
        rg(REG_PRESCALE, 8'h96);
        ep(DEC, 8'h00);
        ep(DEC, 8'h00);
        rg(REG_PRESCALE, 8'h94);
        bus(1'b1, REG_CTRL_A, 8'h80);
        bus(1'b1, REG_INT_STAT, 8'h00);
        ep(INC, 8'h00);
        rg(REG_PRESCALE, 8'h94);
        rg(REG_INT_STAT, 8'h40);
        ep(COM, 8'h00);
        rg(REG_PRESCALE, 8'h95);
        ep(DEC, 8'h00);
        ep(COM, 8'h00);
        rg(REG_PRESCALE, 8'h94);
        $display("ratio test done");
        bus(1'b1, REG_CTRL_A, 8'h8a);
        chk({cmode, filt, sens, ck_en}, 4'hd);
        bus(1'b1, REG_CTRL_B, 8'h04);
        chk(alt, 1'b0);
        ep(COM, 8'h00);
        chk(alt, 1'b1);
        bus(1'b1, REG_CTRL_A, 8'ha2);
        chk({sens, alt}, 2'b10);
        bus(1'b1, REG_CTRL_A, 8'h90);
        bus(1'b1, REG_PHASE, 8'h2a);
        @(posedge clk_sys_i);
        chk({ph.oe_n, pins, ck_en}, {6'h00, 6'h2a, 1'b0});
        bus(1'b1, REG_TIMER, 8'h33);
        rg(REG_TIMER, 8'h33);
        bus(1'b1, REG_CTRL_A, 8'h00);
        chk({ph.oe_n, ck_en}, {6'h3f, 1'b0});
        bus(1'b1, REG_WEIGHT, 8'h5a);
        bus(1'b1, REG_CTRL_A, 8'h40);
        rg(REG_WEIGHT, 8'h00);
        rg(REG_CTRL_A, 8'h00);
        $display("mode test done");
        conclude();
    end
endmodule
